// ---- design/fpd_regs.vh ----
// Constants for the front-panel display mode controller
`ifndef FPD_REGS_VH
`define FPD_REGS_VH

// Display modes in cycle order
`define FPD_MODE_STATUS     4'h0
`define FPD_MODE_TUNING     4'h1
`define FPD_MODE_DIAG       4'h2
`define FPD_MODE_ALARM      4'h3
`define FPD_MODE_POINT      4'h4
`define FPD_MODE_BASIC      4'h5
`define FPD_MODE_GAIN       4'h6
`define FPD_MODE_EXT        4'h7
`define FPD_MODE_IO         4'h8
`define FPD_MODE_EXT2       4'h9
`define FPD_MODE_EXT3       4'hA
`define FPD_MODE_LAST       4'hB

// Control methods
`define FPD_METHOD_POINT    2'h0
`define FPD_METHOD_PROGRAM  2'h1

// Last index of selectable items
`define FPD_STATUS_LAST     4'hA
`define FPD_DIAG_LAST       4'hA
`define FPD_ALARM_LAST      4'h2

// Display geometry
`define FPD_DIGITS          5
`define FPD_SEG_W           40

// Character codes beyond the hex digits
`define FPD_CH_BLANK        5'h10
`define FPD_CH_P            5'h11
`define FPD_CH_O            5'h12
`define FPD_CH_S            5'h13
`define FPD_CH_R            5'h14
`define FPD_CH_N            5'h15
`define FPD_CH_U            5'h16
`define FPD_CH_L            5'h17
`define FPD_CH_J            5'h18
`define FPD_CH_T            5'h19
`define FPD_CH_DASH         5'h1A

// Symbol hold time at power-on
`define FPD_CLK_KHZ         40000
`define FPD_HOLD_MS         2000
`define FPD_HOLD_CYCLES     (`FPD_HOLD_MS * `FPD_CLK_KHZ)

`endif

// ---- design/fpd_front_panel.v ----
// Front-panel display mode controller with power-on intro and status stepping
//
// What this block does
// - Each mode press after the intro advances to next mode
// - Twelve modes in fixed status-to-positioning order
// - Point-table mode only under point-table method
// - Power-on shows positioning text for point/program
// - Status shown on five-digit seven-segment display
// - Up/down step status items, showing symbol
// - Set switches symbol to item data
// - Power-on shows selected symbol 2 s, then data
// - Configured axis name shown before status
// - Alarm mode offers three sub-displays
// - Diagnosis mode offers eleven sub-functions
`timescale 1ns/10ps
`include "fpd_regs.vh"

module fpd_front_panel #(
    parameter [31:0] HOLD_CYCLES = `FPD_HOLD_CYCLES
) (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        BTN_MODE,
    input  wire        BTN_UP,
    input  wire        BTN_DOWN,
    input  wire        BTN_SET,
    input  wire [1:0]  CTRL_METHOD,
    input  wire [3:0]  POWER_ON_STATUS_SELECTOR,
    input  wire        AXIS_NAME_SET,
    input  wire [24:0] AXIS_NAME,
    input  wire [19:0] STATUS_DATA,
    input  wire        STATUS_NEG,
    output reg  [39:0] SEG,
    output reg  [3:0]  DISPLAY_MODE,
    output reg  [3:0]  STATUS_ITEM,
    output reg  [3:0]  SUB_INDEX,
    output reg         SHOW_DATA,
    output reg         INTRO_BUSY
);

    localparam [1:0] PH_AXIS = 2'h0;
    localparam [1:0] PH_POS  = 2'h1;
    localparam [1:0] PH_SYM  = 2'h2;
    localparam [1:0] PH_RUN  = 2'h3;

    // Seven-segment pattern, bit order g..a, active high
    function [6:0] seg_of;
        input [4:0] ch;
        begin
            case (ch)
                5'h00:          seg_of = 7'h3F;
                5'h01:          seg_of = 7'h06;
                5'h02:          seg_of = 7'h5B;
                5'h03:          seg_of = 7'h4F;
                5'h04:          seg_of = 7'h66;
                5'h05:          seg_of = 7'h6D;
                5'h06:          seg_of = 7'h7D;
                5'h07:          seg_of = 7'h07;
                5'h08:          seg_of = 7'h7F;
                5'h09:          seg_of = 7'h6F;
                5'h0A:          seg_of = 7'h77;
                5'h0B:          seg_of = 7'h7C;
                5'h0C:          seg_of = 7'h39;
                5'h0D:          seg_of = 7'h5E;
                5'h0E:          seg_of = 7'h79;
                5'h0F:          seg_of = 7'h71;
                `FPD_CH_P:      seg_of = 7'h73;
                `FPD_CH_O:      seg_of = 7'h5C;
                `FPD_CH_S:      seg_of = 7'h6D;
                `FPD_CH_R:      seg_of = 7'h50;
                `FPD_CH_N:      seg_of = 7'h54;
                `FPD_CH_U:      seg_of = 7'h3E;
                `FPD_CH_L:      seg_of = 7'h38;
                `FPD_CH_J:      seg_of = 7'h1E;
                `FPD_CH_T:      seg_of = 7'h78;
                `FPD_CH_DASH:   seg_of = 7'h40;
                default:        seg_of = 7'h00;
            endcase
        end
    endfunction

    // Symbol letter of each status item
    function [4:0] sym_of;
        input [3:0] item;
        begin
            case (item)
                4'h0:    sym_of = 5'h0C;
                4'h1:    sym_of = `FPD_CH_R;
                4'h2:    sym_of = 5'h0E;
                4'h3:    sym_of = `FPD_CH_P;
                4'h4:    sym_of = `FPD_CH_N;
                4'h5:    sym_of = 5'h0F;
                4'h6:    sym_of = `FPD_CH_U;
                4'h7:    sym_of = `FPD_CH_L;
                4'h8:    sym_of = `FPD_CH_J;
                4'h9:    sym_of = 5'h0B;
                4'hA:    sym_of = `FPD_CH_T;
                default: sym_of = `FPD_CH_DASH;
            endcase
        end
    endfunction

    // Step an index up or down with wrap across 0..last
    // An index beyond last recovers to an end
    function [3:0] step;
        input [3:0] cur;
        input [3:0] last;
        input       up;
        begin
            if (up) begin
                step = (cur >= last) ? 4'h0 : cur + 4'h1;
            end else begin
                step = (cur == 4'h0 || cur > last) ? last : cur - 4'h1;
            end
        end
    endfunction

    // Pack five characters into the segment bus, digit 4 leftmost
    function [39:0] pack;
        input [24:0] chars;
        input [4:0]  dots;
        integer k;
        begin
            pack = 40'h00_0000_0000;
            for (k = 0; k < `FPD_DIGITS; k = k + 1) begin
                pack[k*8 +: 8] = {dots[k], seg_of(chars[k*5 +: 5])};
            end
        end
    endfunction

    // Button pins pass two flip-flops before use
    reg  [3:0]  btn_meta;
    reg  [3:0]  btn_sync;
    reg  [3:0]  btn_prev;
    wire [3:0]  press = btn_sync & ~btn_prev;
    wire        press_mode = press[0];
    wire        press_up   = press[1];
    wire        press_down = press[2];
    wire        press_set  = press[3];

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            btn_meta <= 4'h0;
            btn_sync <= 4'h0;
            btn_prev <= 4'h0;
        end else begin
            btn_meta <= {BTN_SET, BTN_DOWN, BTN_UP, BTN_MODE};
            btn_sync <= btn_meta;
            btn_prev <= btn_sync;
        end
    end

    reg  [1:0]  phase;
    reg  [31:0] timer;
    reg  [1:0]  next_phase;
    wire        point_method = (CTRL_METHOD == `FPD_METHOD_POINT);
    wire        pos_method   = point_method || (CTRL_METHOD == `FPD_METHOD_PROGRAM);
    wire        timer_done   = (timer >= HOLD_CYCLES - 32'h0000_0001);

    // Intro sequence: axis name, positioning text, symbol, then run
    always @* begin
        next_phase = phase;
        case (phase)
            PH_AXIS: begin
                if (!AXIS_NAME_SET || timer_done) begin
                    next_phase = pos_method ? PH_POS : PH_SYM;
                end
            end
            PH_POS: begin
                if (timer_done) begin
                    next_phase = PH_SYM;
                end
            end
            PH_SYM: begin
                if (timer_done) begin
                    next_phase = PH_RUN;
                end
            end
            PH_RUN: begin
                next_phase = PH_RUN;
            end
            default: begin
                next_phase = PH_RUN;
            end
        endcase
    end

    reg  [3:0]  mode;
    reg  [3:0]  item;
    reg  [3:0]  sub;
    reg         show;
    reg  [3:0]  next_mode;

    // Skip the point-table mode outside the point-table method
    always @* begin
        if (mode >= `FPD_MODE_LAST) begin
            next_mode = `FPD_MODE_STATUS;
        end else if (mode + 4'h1 == `FPD_MODE_POINT && !point_method) begin
            next_mode = mode + 4'h2;
        end else begin
            next_mode = mode + 4'h1;
        end
    end

    wire        run = (phase == PH_RUN);
    wire [3:0]  sub_last = (mode == `FPD_MODE_ALARM) ? `FPD_ALARM_LAST : `FPD_DIAG_LAST;

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase <= PH_AXIS;
            timer <= 32'h0000_0000;
            mode  <= `FPD_MODE_STATUS;
            item  <= 4'h0;
            sub   <= 4'h0;
            show  <= 1'b0;
        end else begin
            phase <= next_phase;
            // Timer parks after the intro so it never wraps
            if (next_phase != phase) begin
                timer <= 32'h0000_0000;
            end else if (!run) begin
                timer <= timer + 32'h0000_0001;
            end
            if (!run) begin
                // Selector sampled until the intro ends, so late config still lands
                item <= (POWER_ON_STATUS_SELECTOR > `FPD_STATUS_LAST) ?
                        4'h0 : POWER_ON_STATUS_SELECTOR;
                show <= (next_phase == PH_RUN);
            end else if (press_mode) begin
                mode <= next_mode;
                sub  <= 4'h0;
                show <= 1'b0;
            end else if (mode == `FPD_MODE_STATUS) begin
                // Up wins when both arrows land together
                if (press_up || press_down) begin
                    item <= step(item, `FPD_STATUS_LAST, press_up);
                    show <= 1'b0;
                end else if (press_set) begin
                    show <= 1'b1;
                end
            end else if (mode == `FPD_MODE_DIAG || mode == `FPD_MODE_ALARM) begin
                if (press_up || press_down) begin
                    sub <= step(sub, sub_last, press_up);
                end
            end
        end
    end

    // Compose the five-digit picture
    reg  [39:0] next_seg;
    always @* begin
        case (phase)
            PH_AXIS: begin
                // Blank rather than stray name bits when none is configured
                if (AXIS_NAME_SET) begin
                    next_seg = pack(AXIS_NAME, 5'h00);
                end else begin
                    next_seg = 40'h00_0000_0000;
                end
            end
            PH_POS: begin
                next_seg = pack({`FPD_CH_P, `FPD_CH_O, `FPD_CH_S, `FPD_CH_BLANK,
                                 `FPD_CH_BLANK}, 5'h00);
            end
            PH_SYM: begin
                next_seg = pack({sym_of(item), {4{`FPD_CH_BLANK}}}, 5'h00);
            end
            default: begin
                if (mode != `FPD_MODE_STATUS) begin
                    next_seg = pack({`FPD_CH_DASH, 1'b0, mode, `FPD_CH_BLANK,
                                     `FPD_CH_BLANK, 1'b0, sub}, 5'h00);
                end else if (show) begin
                    // Negative values light the upper four decimal points
                    next_seg = pack({1'b0, STATUS_DATA[19:16], 1'b0, STATUS_DATA[15:12],
                                     1'b0, STATUS_DATA[11:8], 1'b0, STATUS_DATA[7:4],
                                     1'b0, STATUS_DATA[3:0]},
                                    {{4{STATUS_NEG}}, 1'b0});
                end else begin
                    next_seg = pack({sym_of(item), {4{`FPD_CH_BLANK}}}, 5'h00);
                end
            end
        endcase
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SEG          <= 40'h00_0000_0000;
            DISPLAY_MODE <= `FPD_MODE_STATUS;
            STATUS_ITEM  <= 4'h0;
            SUB_INDEX    <= 4'h0;
            SHOW_DATA    <= 1'b0;
            INTRO_BUSY   <= 1'b1;
        end else begin
            SEG          <= next_seg;
            DISPLAY_MODE <= mode;
            STATUS_ITEM  <= item;
            SUB_INDEX    <= sub;
            SHOW_DATA    <= show;
            INTRO_BUSY   <= !run;
        end
    end

endmodule

// ---- testbench/fpd_front_panel_checker.sv ----
// Assertion checker for the front-panel display controller
`timescale 1ns/10ps
module fpd_front_panel_checker #(
    parameter [31:0] HOLD_CYCLES = 32'h0000_0014
) (
    input wire        CLK,
    input wire        RST_N,
    input wire        BTN_MODE,
    input wire        BTN_SET,
    input wire [1:0]  CTRL_METHOD,
    input wire        STATUS_NEG,
    input wire [39:0] SEG,
    input wire [3:0]  DISPLAY_MODE,
    input wire [3:0]  STATUS_ITEM,
    input wire [3:0]  SUB_INDEX,
    input wire        SHOW_DATA,
    input wire        INTRO_BUSY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_mode_press;
        !INTRO_BUSY && $rose(BTN_MODE);
    endsequence
    sequence s_set_press;
        !INTRO_BUSY && DISPLAY_MODE == 4'h0 && !SHOW_DATA && $rose(BTN_SET);
    endsequence
    // Data view held long enough for the sign to reach the segments
    sequence s_data_steady;
        (SHOW_DATA && DISPLAY_MODE == 4'h0 && $stable(STATUS_NEG))[*4];
    endsequence
    AST_MODE_PRESS:
    assert property (s_mode_press |-> ##[2:8] $changed(DISPLAY_MODE)) else $error("no mode step");
    AST_MODE_NEXT:
    assert property ($changed(DISPLAY_MODE) && $past(DISPLAY_MODE) < 4'hB
        && $past(DISPLAY_MODE) != 4'h3 |-> DISPLAY_MODE == $past(DISPLAY_MODE) + 4'h1)
        else $error("mode order broken");
    AST_POINT_SKIP:
    assert property ($changed(DISPLAY_MODE) && $past(DISPLAY_MODE) == 4'h3
        |-> DISPLAY_MODE == (CTRL_METHOD == 2'h0 ? 4'h4 : 4'h5)) else $error("point skip wrong");
    AST_MODE_WRAP:
    assert property ($changed(DISPLAY_MODE) && $past(DISPLAY_MODE) == 4'hB
        |-> DISPLAY_MODE == 4'h0) else $error("mode wrap wrong");
    AST_INTRO_HOLD:
    assert property (INTRO_BUSY |-> DISPLAY_MODE == 4'h0 && !SHOW_DATA) else $error("intro left");
    AST_INTRO_END:
    assert property ($fell(INTRO_BUSY) |-> SHOW_DATA) else $error("intro ends without data");
    AST_STEP_ITEM:
    assert property ($changed(STATUS_ITEM) && !INTRO_BUSY && !$past(INTRO_BUSY) |-> !SHOW_DATA
        && (STATUS_ITEM == ($past(STATUS_ITEM) == 4'hA ? 4'h0 : $past(STATUS_ITEM) + 4'h1)
        || STATUS_ITEM == ($past(STATUS_ITEM) == 4'h0 ? 4'hA : $past(STATUS_ITEM) - 4'h1)))
        else $error("item step wrong");
    AST_SET_DATA:
    assert property (s_set_press |-> ##[2:8] SHOW_DATA) else $error("set ignored");
    AST_AWAY_SYMBOL:
    assert property (DISPLAY_MODE != 4'h0 |-> !SHOW_DATA) else $error("data outside status");
    AST_NEG_POINTS:
    assert property (s_data_steady |-> {SEG[39], SEG[31], SEG[23], SEG[15], SEG[7]}
        == {{4{STATUS_NEG}}, 1'b0}) else $error("sign points wrong");
    AST_ALARM_SUB:
    assert property (DISPLAY_MODE == 4'h3 |-> SUB_INDEX <= 4'h2) else $error("alarm sub range");
    AST_DIAG_SUB:
    assert property (DISPLAY_MODE == 4'h2 |-> SUB_INDEX <= 4'hA) else $error("diag sub range");
endmodule

bind fpd_front_panel fpd_front_panel_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .CLK(CLK), .RST_N(RST_N), .BTN_MODE(BTN_MODE), .BTN_SET(BTN_SET),
    .CTRL_METHOD(CTRL_METHOD), .STATUS_NEG(STATUS_NEG), .SEG(SEG),
    .DISPLAY_MODE(DISPLAY_MODE), .STATUS_ITEM(STATUS_ITEM), .SUB_INDEX(SUB_INDEX),
    .SHOW_DATA(SHOW_DATA), .INTRO_BUSY(INTRO_BUSY));

// ---- testbench/fpd_buttons.sv ----
// Push-button model giving clean presses to the panel
`timescale 1ns/10ps
module fpd_buttons (
    input  wire        clk,
    output logic [3:0] btn
);
    initial btn = 4'h0;
    // No bounce; the long gap lets the panel answer before the next press
    task automatic press(input int k);
        @(negedge clk);
        btn[k] = 1'b1;
        repeat (3) @(negedge clk);
        btn[k] = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ---- testbench/fpd_front_panel_tb.sv ----
// Self-checking bench for the front-panel display controller
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module fpd_front_panel_tb;
    localparam int HOLD = 20;
    logic        CLK, RST_N, axis_set, neg;
    logic [1:0]  method;
    logic [3:0]  sel, exp_item, exp_mode;
    logic [19:0] sdata;
    logic [24:0] axis;
    wire  [3:0]  btn, mode, item, sub;
    wire  [39:0] seg;
    wire         show, busy;
    int          fails, comparisons, cyc, n, e, k;
    fpd_buttons u_fpd_buttons (.clk(CLK), .btn(btn));
    fpd_front_panel #(.HOLD_CYCLES(HOLD)) u_fpd_front_panel (
        .CLK(CLK), .RST_N(RST_N), .BTN_MODE(btn[0]), .BTN_UP(btn[1]), .BTN_DOWN(btn[2]),
        .BTN_SET(btn[3]), .CTRL_METHOD(method), .POWER_ON_STATUS_SELECTOR(sel),
        .AXIS_NAME_SET(axis_set), .AXIS_NAME(axis), .STATUS_DATA(sdata), .STATUS_NEG(neg),
        .SEG(seg), .DISPLAY_MODE(mode), .STATUS_ITEM(item), .SUB_INDEX(sub),
        .SHOW_DATA(show), .INTRO_BUSY(busy));
    function automatic logic [3:0] next_mode(input logic [3:0] m, input logic [1:0] t);
        if (m == 4'hB) return 4'h0;
        if (m == 4'h3 && t != 2'h0) return 4'h5;
        return m + 4'h1;
    endfunction
    function automatic logic [3:0] step_item(input logic [3:0] i, input logic up);
        if (up) return (i == 4'hA) ? 4'h0 : i + 4'h1;
        return (i == 4'h0) ? 4'hA : i - 4'h1;
    endfunction
    // Eleven diagnosis sub-functions, three alarm sub-displays
    function automatic logic [3:0] sub_after(input logic [3:0] m, input int ups);
        if (m == 4'h2) return 4'(ups % 11);
        if (m == 4'h3) return 4'(ups % 3);
        return 4'h0;
    endfunction
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // Four configurations take about 2900 cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        {RST_N, axis_set, neg, method, sel, sdata, axis} = '0;
        void'($urandom(31648));
        for (int c = 0; c < 4; c++) begin
            @(negedge CLK);
            RST_N = 1'b0;
            axis_set = c[0];
            method = (c == 3) ? 2'($urandom_range(2, 3)) : c[1:0];
            sel = (c == 0) ? 4'hF : 4'($urandom_range(0, 15));
            axis = 25'($urandom);
            sdata = 20'($urandom);
            repeat (4) @(negedge CLK);
            RST_N = 1'b1;
            n = 0;
            while (busy === 1'b1 && n < 300) begin
                @(negedge CLK);
                n++;
            end
            e = HOLD * (1 + axis_set + (method < 2'h2));
            `CHK("intro_len", 1'b1, n >= e - 1 && n <= e + 4);
            exp_item = (sel > 4'hA) ? 4'h0 : sel;
            `CHK("item", exp_item, item);
            `CHK("show", 1'b1, show);
            for (int j = 0; j < 12; j++) begin
                k = (j == 0) ? 2 : (j == 1) ? 1 : $urandom_range(1, 2);
                u_fpd_buttons.press(k);
                exp_item = step_item(exp_item, k == 1);
                `CHK("item", exp_item, item);
                `CHK("show", 1'b0, show);
                neg = 1'($urandom);
                sdata = 20'($urandom);
            end
            u_fpd_buttons.press(3);
            `CHK("show", 1'b1, show);
            `CHK("dots", {{4{neg}}, 1'b0}, {seg[39], seg[31], seg[23], seg[15], seg[7]});
            exp_mode = 4'h0;
            repeat (14) begin
                u_fpd_buttons.press(0);
                exp_mode = next_mode(exp_mode, method);
                `CHK("mode", exp_mode, mode);
                if (exp_mode >= 4'h1 && exp_mode <= 4'h3) begin
                    repeat (4) u_fpd_buttons.press(1);
                    u_fpd_buttons.press(3);
                    `CHK("item", exp_item, item);
                    `CHK("show", 1'b0, show);
                    `CHK("sub", sub_after(exp_mode, 4), sub);
                end
            end
        end
        conclude();
    end
endmodule
